// [src/boot_loader_defines.vh]
`ifndef BOOT_LOADER_DEFINES_VH
`define BOOT_LOADER_DEFINES_VH

// boot source codes, two-pin form
`define SRC_SPI_SLAVE       2'h0
`define SRC_SPI_MASTER      2'h1
`define SRC_PAR_PROM        2'h2
`define SRC_NO_BOOT         2'h3
// three-pin codes, link port on wide variant
`define WSRC_SPI_SLAVE      3'h0
`define WSRC_SPI_MASTER     3'h1
`define WSRC_PAR_PROM       3'h2
`define WSRC_NO_BOOT        3'h3
`define WSRC_LINK           3'h4
// boot source encoding on the outputs
`define BSRC_SPI_SLAVE      3'h0
`define BSRC_SPI_MASTER     3'h1
`define BSRC_PAR_PROM       3'h2
`define BSRC_NO_BOOT        3'h3
`define BSRC_LINK           3'h4
`define BSRC_INVALID        3'h7
// kernel transfer counts
`define CNT_32BIT_WORDS     9'h180
`define CNT_48BIT_WORDS     9'h100
`define CNT_ZERO            9'h000
`define CNT_ONE             9'h001
// word widths
`define WORD_W_32           6'h20
`define WORD_W_48           6'h30
// variants
`define VAR_A               2'h0
`define VAR_B               2'h1
`define VAR_C               2'h2
// kernel base and reset vector per variant
`define KBASE_A             20'h80000
`define KBASE_B             20'h90000
`define KBASE_C             20'h8C000
`define RVEC_A              20'h80004
`define RVEC_B              20'h90004
`define RVEC_C              20'h8C004
`define KERNEL_LAST_OFS     20'h000FF
// spi master address lengths
`define SPI_ADDR_NONE       2'h0
`define SPI_ADDR_16         2'h1
`define SPI_ADDR_24         2'h2
// processor id
`define PROC_ID_W           3
`define PROC_ID_ZERO        3'h0
// settle count before the pins are taken
`define SETTLE_ZERO         2'h0
`define SETTLE_STEP         2'h1
`define SETTLE_LAST         2'h2

`endif

// [src/power_up_boot_loader.v]
`timescale 1ns/10ps
`include "boot_loader_defines.vh"

module power_up_boot_loader #(
	parameter [1:0] VARIANT  = `VAR_A,
	parameter       WIDE_CFG = 0,
	parameter       HAS_LINK = 0,
	parameter       HAS_ROM  = 1,
	parameter       MULTI_ID = 0
) (
	// clock and reset
	input  wire        mclk_i,
	input  wire        rst_i,
	// boot configuration pins
	input  wire [1:0]  boot_select_pins_i,
	input  wire [2:0]  boot_select_pins_wide_i,
	input  wire [1:0]  spi_addr_len_i,
	input  wire [2:0]  proc_id_i,
	// boot dma word stream
	input  wire        dma_word_valid_i,
	output reg         dma_word_ready_o,
	// kernel progress
	input  wire        kernel_done_i,
	input  wire        app_overwrite_done_i,
	input  wire [2:0]  stream_proc_id_i,
	input  wire        stream_id_valid_i,
	// status and control outputs
	output reg  [2:0]  boot_source_o,
	output reg         dma_start_o,
	output reg  [8:0]  dma_count_o,
	output reg  [5:0]  dma_word_width_o,
	output reg  [19:0] kernel_base_o,
	output reg  [19:0] kernel_last_o,
	output reg  [19:0] reset_vector_o,
	output reg         kernel_run_o,
	output reg         app_run_o,
	output reg         rom_run_o,
	output reg         vector_table_internal_o,
	output reg         peripheral_pin_routing_o,
	output reg  [1:0]  spi_addr_mode_o,
	output reg         id_match_o,
	output reg         boot_error_o
);

	localparam [5:0] ST_SAMPLE = 6'h01;
	localparam [5:0] ST_DECODE = 6'h02;
	localparam [5:0] ST_DMA    = 6'h04;
	localparam [5:0] ST_KERNEL = 6'h08;
	localparam [5:0] ST_APP    = 6'h10;
	localparam [5:0] ST_ROM    = 6'h20;

	// two-stage synchronisers for pins
	reg  [1:0]  sel_s1_r;
	reg  [1:0]  sel_s2_r;
	reg  [2:0]  wsel_s1_r;
	reg  [2:0]  wsel_s2_r;
	reg  [1:0]  alen_s1_r;
	reg  [1:0]  alen_s2_r;
	reg  [2:0]  pid_s1_r;
	reg  [2:0]  pid_s2_r;

	reg  [5:0]  state_r;
	reg  [5:0]  state_nxt;
	reg  [1:0]  settle_r;
	reg  [2:0]  src_r;
	reg  [2:0]  own_id_r;
	reg  [8:0]  remain_r;

	function [2:0] decode_src;
		input [1:0] narrow;
		input [2:0] wide;
		begin
			if (WIDE_CFG != 0) begin
				case (wide)
					`WSRC_SPI_SLAVE:  decode_src = `BSRC_SPI_SLAVE;
					`WSRC_SPI_MASTER: decode_src = `BSRC_SPI_MASTER;
					`WSRC_PAR_PROM:   decode_src = `BSRC_PAR_PROM;
					`WSRC_NO_BOOT:    decode_src = (HAS_ROM != 0) ? `BSRC_NO_BOOT : `BSRC_INVALID;
					`WSRC_LINK:       decode_src = (HAS_LINK != 0) ? `BSRC_LINK : `BSRC_INVALID;
					default:          decode_src = `BSRC_INVALID;
				endcase
			end else begin
				case (narrow)
					`SRC_SPI_SLAVE:  decode_src = `BSRC_SPI_SLAVE;
					`SRC_SPI_MASTER: decode_src = `BSRC_SPI_MASTER;
					`SRC_PAR_PROM:   decode_src = `BSRC_PAR_PROM;
					default:         decode_src = (HAS_ROM != 0) ? `BSRC_NO_BOOT : `BSRC_INVALID;
				endcase
			end
		end
	endfunction

	function [19:0] variant_base;
		input [1:0] v;
		begin
			case (v)
				`VAR_B:  variant_base = `KBASE_B;
				`VAR_C:  variant_base = `KBASE_C;
				default: variant_base = `KBASE_A;
			endcase
		end
	endfunction

	function [19:0] variant_vector;
		input [1:0] v;
		begin
			case (v)
				`VAR_B:  variant_vector = `RVEC_B;
				`VAR_C:  variant_vector = `RVEC_C;
				default: variant_vector = `RVEC_A;
			endcase
		end
	endfunction

	function [19:0] variant_last;
		input [1:0]  v;
		reg   [20:0] sum;
		begin
			sum          = {1'h0, variant_base(v)} + {1'h0, `KERNEL_LAST_OFS};
			variant_last = sum[19:0];
		end
	endfunction

	function needs_dma;
		input [2:0] src;
		begin
			needs_dma = (src != `BSRC_NO_BOOT) && (src != `BSRC_INVALID);
		end
	endfunction

	// pin synchronisers
	always @(posedge mclk_i) begin
		sel_s1_r  <= boot_select_pins_i;
		sel_s2_r  <= sel_s1_r;
		wsel_s1_r <= boot_select_pins_wide_i;
		wsel_s2_r <= wsel_s1_r;
		alen_s1_r <= spi_addr_len_i;
		alen_s2_r <= alen_s1_r;
		pid_s1_r  <= proc_id_i;
		pid_s2_r  <= pid_s1_r;
	end

	// sequencer next state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_SAMPLE: begin
				if (settle_r == `SETTLE_LAST)
					state_nxt = ST_DECODE;
			end
			ST_DECODE: begin
				if (src_r == `BSRC_NO_BOOT)
					state_nxt = ST_ROM;
				else if (needs_dma(src_r))
					state_nxt = ST_DMA;
			end
			ST_DMA: begin
				if (dma_word_valid_i && (remain_r == `CNT_ONE))
					state_nxt = ST_KERNEL;
			end
			ST_KERNEL: begin
				if (kernel_done_i && app_overwrite_done_i)
					state_nxt = ST_APP;
			end
			ST_APP:  state_nxt = ST_APP;
			ST_ROM:  state_nxt = ST_ROM;
			default: state_nxt = ST_SAMPLE;
		endcase
	end

	// sequencer state register
	always @(posedge mclk_i) begin
		if (rst_i)
			state_r <= ST_SAMPLE;
		else
			state_r <= state_nxt;
	end

	// settle count after reset release
	always @(posedge mclk_i) begin
		if (rst_i)
			settle_r <= `SETTLE_ZERO;
		else if (state_r == ST_SAMPLE)
			settle_r <= settle_r + `SETTLE_STEP;
	end

	// one-time capture of the synchronised pins
	always @(posedge mclk_i) begin
		if (rst_i) begin
			src_r           <= `BSRC_INVALID;
			own_id_r        <= `PROC_ID_ZERO;
			spi_addr_mode_o <= `SPI_ADDR_NONE;
		end else if (state_r == ST_SAMPLE && settle_r == `SETTLE_LAST) begin
			// caught once after release, held until next reset
			src_r           <= decode_src(sel_s2_r, wsel_s2_r);
			own_id_r        <= pid_s2_r;
			spi_addr_mode_o <= alen_s2_r;
		end
	end

	// boot source report and error flag
	always @(posedge mclk_i) begin
		if (rst_i) begin
			boot_source_o <= `BSRC_INVALID;
			boot_error_o  <= 1'h0;
		end else if (state_r == ST_DECODE) begin
			boot_source_o <= src_r;
			boot_error_o  <= (src_r == `BSRC_INVALID);
		end
	end

	// kernel dma set-up and word count
	always @(posedge mclk_i) begin
		if (rst_i) begin
			dma_start_o      <= 1'h0;
			dma_word_ready_o <= 1'h0;
			dma_count_o      <= `CNT_ZERO;
			dma_word_width_o <= `WORD_W_32;
			remain_r         <= `CNT_ZERO;
		end else begin
			dma_start_o <= 1'h0;
			if (state_r == ST_DECODE && needs_dma(src_r)) begin
				dma_start_o      <= 1'h1;
				dma_word_ready_o <= 1'h1;
				if (src_r == `BSRC_PAR_PROM) begin
					remain_r         <= `CNT_48BIT_WORDS;
					dma_count_o      <= `CNT_48BIT_WORDS;
					dma_word_width_o <= `WORD_W_48;
				end else begin
					remain_r         <= `CNT_32BIT_WORDS;
					dma_count_o      <= `CNT_32BIT_WORDS;
					dma_word_width_o <= `WORD_W_32;
				end
			end
			if (state_r == ST_DMA && dma_word_valid_i) begin
				remain_r <= remain_r - `CNT_ONE;
				if (remain_r == `CNT_ONE)
					dma_word_ready_o <= 1'h0;
			end
		end
	end

	// kernel, application and rom run flags
	always @(posedge mclk_i) begin
		if (rst_i) begin
			kernel_run_o <= 1'h0;
			app_run_o    <= 1'h0;
			rom_run_o    <= 1'h0;
		end else begin
			if (state_r == ST_DMA && dma_word_valid_i && remain_r == `CNT_ONE)
				kernel_run_o <= 1'h1;
			if (state_r == ST_KERNEL && kernel_done_i && app_overwrite_done_i) begin
				kernel_run_o <= 1'h0;
				app_run_o    <= 1'h1;
			end
			if (state_r == ST_DECODE && src_r == `BSRC_NO_BOOT)
				rom_run_o <= 1'h1;
		end
	end

	// processor id match for shared prom streams
	always @(posedge mclk_i) begin
		if (rst_i)
			id_match_o <= 1'h0;
		else if (state_r == ST_KERNEL && stream_id_valid_i && (MULTI_ID != 0)
				&& (src_r == `BSRC_PAR_PROM))
			id_match_o <= (stream_proc_id_i == own_id_r);
	end

	// fixed kernel range and reset vector
	always @(posedge mclk_i) begin
		if (rst_i) begin
			kernel_base_o  <= variant_base(VARIANT);
			kernel_last_o  <= variant_last(VARIANT);
			reset_vector_o <= variant_vector(VARIANT);
		end else begin
			kernel_base_o  <= variant_base(VARIANT);
			kernel_last_o  <= variant_last(VARIANT);
			reset_vector_o <= variant_vector(VARIANT);
		end
	end

	// vector table placement and boot pin routing
	always @(posedge mclk_i) begin
		if (rst_i) begin
			vector_table_internal_o  <= 1'h1;
			peripheral_pin_routing_o <= 1'h1;
		end else begin
			vector_table_internal_o  <= 1'h1;
			peripheral_pin_routing_o <= 1'h1;
		end
	end

endmodule // power_up_boot_loader

// [sim/boot_loader_sva.sv]
`timescale 1ns/10ps
module boot_loader_sva (
	input wire logic        mclk_i, rst_i, kernel_done_i, app_overwrite_done_i,
	input wire logic        dma_word_ready_o, dma_start_o, kernel_run_o, app_run_o,
	input wire logic        rom_run_o, vector_table_internal_o, peripheral_pin_routing_o,
	input wire logic [2:0]  boot_source_o,
	input wire logic [8:0]  dma_count_o,
	input wire logic [5:0]  dma_word_width_o,
	input wire logic [19:0] kernel_base_o, kernel_last_o, reset_vector_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	property p_start; $rose(dma_word_ready_o) |-> dma_start_o; endproperty
	a_start: assert property (p_start) else $error("no start pulse");
	property p_size; dma_start_o |-> (boot_source_o == 3'h2) ?
		(dma_count_o == 9'h100 && dma_word_width_o == 6'h30) :
		(dma_count_o == 9'h180 && dma_word_width_o == 6'h20); endproperty
	a_size: assert property (p_size) else $error("bad dma size");
	property p_krun; $fell(dma_word_ready_o) |-> kernel_run_o; endproperty
	a_krun: assert property (p_krun) else $error("kernel idle");
	property p_app; kernel_run_o && kernel_done_i && app_overwrite_done_i |=> app_run_o; endproperty
	a_app: assert property (p_app) else $error("no app run");
	property p_rom; rom_run_o |-> boot_source_o == 3'h3 && !dma_word_ready_o; endproperty
	a_rom: assert property (p_rom) else $error("rom run wrong");
	property p_fix; vector_table_internal_o && peripheral_pin_routing_o; endproperty
	a_fix: assert property (p_fix) else $error("fixed flags low");
	property p_last; kernel_last_o == kernel_base_o + 20'h000FF; endproperty
	a_last: assert property (p_last) else $error("bad kernel end");
	property p_vec; reset_vector_o == kernel_base_o + 20'h00004; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_hold; boot_source_o != 3'h7 |=> $stable(boot_source_o); endproperty
	a_hold: assert property (p_hold) else $error("source moved");
endmodule // boot_loader_sva
bind power_up_boot_loader boot_loader_sva chk (.*);

// [sim/kernel_source_model.sv]
`timescale 1ns/10ps
module kernel_source_model (
	input  wire logic       mclk_i, rst_i, ready_i, slow_i,
	input  wire logic [8:0] cnt_i,
	output logic            valid_o,
	output logic [8:0]      words_o
);
	logic [1:0] gap_r = 2'h0;
	always @(posedge mclk_i) begin
		gap_r <= gap_r + 2'h1;
		if (rst_i) begin
			valid_o <= 1'h0;
			words_o <= 9'h000;
		end else begin
			if (valid_o && ready_i) words_o <= words_o + 9'h001;
			valid_o <= (words_o + {8'h00, valid_o && ready_i} < cnt_i)
				&& (!slow_i || gap_r == 2'h0);
		end
	end
endmodule // kernel_source_model

// [sim/tb_power_up_boot_loader.sv]
`timescale 1ns/10ps
module tb_power_up_boot_loader;
	logic mclk_i = 1'h0, rst_i = 1'h1, kernel_done_i = 1'h0, app_overwrite_done_i = 1'h0;
	logic [1:0] boot_select_pins_i = 2'h0, spi_addr_len_i = 2'h0;
	logic [2:0] boot_select_pins_wide_i = 3'h0, proc_id_i = 3'h0, stream_proc_id_i = 3'h0;
	logic stream_id_valid_i = 1'h0, slow = 1'h0;
	wire dma_word_valid_i, dma_word_ready_o, dma_start_o, kernel_run_o, app_run_o, rom_run_o;
	wire vector_table_internal_o, peripheral_pin_routing_o, id_match_o, boot_error_o;
	wire [2:0] boot_source_o;
	wire [8:0] dma_count_o, words;
	wire [5:0] dma_word_width_o;
	wire [1:0] spi_addr_mode_o;
	wire [19:0] kernel_base_o, kernel_last_o, reset_vector_o;
	int mismatches = 0, compares = 0;
	power_up_boot_loader dut (.*);
	kernel_source_model far (.mclk_i, .rst_i, .ready_i(dma_word_ready_o), .slow_i(slow),
		.cnt_i(dma_count_o), .valid_o(dma_word_valid_i), .words_o(words));
	always #25 mclk_i = ~mclk_i;
	task automatic cmp(string n, logic [19:0] e, logic [19:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test;
		if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic boot_run(logic [1:0] code, logic [1:0] alen, logic s);
		logic [8:0] n;
		int k;
		n = (code == 2'h2) ? 9'h100 : 9'h180;
		@(posedge mclk_i);
		rst_i <= 1'h1;
		boot_select_pins_i <= code;
		spi_addr_len_i <= alen;
		slow <= s;
		kernel_done_i <= 1'h0;
		app_overwrite_done_i <= 1'h0;
		repeat (3) @(posedge mclk_i);
		@(negedge mclk_i);
		cmp("src_rst", 3'h7, boot_source_o);
		cmp("routing", 1'h1, peripheral_pin_routing_o);
		cmp("vec_table", 1'h1, vector_table_internal_o);
		cmp("vector", 20'h80004, reset_vector_o);
		cmp("k_last", 20'h800FF, kernel_last_o);
		cmp("k_base", 20'h80000, kernel_base_o);
		@(posedge mclk_i) rst_i <= 1'h0;
		for (k = 0; k < 20 && dma_start_o !== 1'h1 && rom_run_o !== 1'h1; k++)
			@(negedge mclk_i);
		cmp("source", code, boot_source_o);
		cmp("error", 1'h0, boot_error_o);
		if (code == 2'h3) begin
			cmp("rom_run", 1'h1, rom_run_o);
			cmp("ready", 1'h0, dma_word_ready_o);
			return;
		end
		cmp("count", n, dma_count_o);
		cmp("start", 1'h1, dma_start_o);
		cmp("width", (code == 2'h2) ? 6'h30 : 6'h20, dma_word_width_o);
		if (code == 2'h1) cmp("addr", alen, spi_addr_mode_o);
		@(posedge mclk_i) boot_select_pins_i <= ~code;
		for (k = 0; k < 2000 && kernel_run_o !== 1'h1; k++) @(negedge mclk_i);
		cmp("kernel_run", 1'h1, kernel_run_o);
		cmp("words", n, words);
		cmp("ready_end", 1'h0, dma_word_ready_o);
		cmp("src_held", code, boot_source_o);
		@(posedge mclk_i) kernel_done_i <= 1'h1;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		cmp("app_early", 1'h0, app_run_o);
		@(posedge mclk_i) app_overwrite_done_i <= 1'h1;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		cmp("app_run", 1'h1, app_run_o);
		cmp("id_match", 1'h0, id_match_o);
	endtask
	task automatic spi_slave_boot;
		boot_run(2'h0, 2'h0, 1'h0);
	endtask
	task automatic spi_master_boot(logic [1:0] alen, logic s);
		boot_run(2'h1, alen, s);
	endtask
	task automatic prom_boot;
		boot_run(2'h2, 2'h0, 1'h0);
	endtask
	task automatic rom_boot;
		boot_run(2'h3, 2'h0, 1'h1);
	endtask
	initial begin
		spi_slave_boot;
		spi_master_boot(2'h0, 1'h1);
		spi_master_boot(2'h1, 1'h0);
		spi_master_boot(2'h2, 1'h1);
		prom_boot;
		rom_boot;
		finish_test;
	end
	initial begin
		#1500000;
		mismatches++;
		finish_test;
	end
endmodule // tb_power_up_boot_loader
